/* rtl/spi_link_if.sv */
// serial link between host controller and status device
`timescale 1ns/1ps
interface spi_link_if;
   logic cs_n;
   logic sck;
   logic mosi;
   logic miso;
   logic miso_oe;
   logic hold_n;
   logic wp_n;
   logic miso_line;

   // floating output seen as high
   assign miso_line = miso_oe ? miso : 1'b1;

   modport device (
      input  cs_n, sck, mosi, hold_n, wp_n,
      output miso, miso_oe
   );
   modport host (
      output cs_n, sck, mosi, hold_n, wp_n,
      input  miso_line
   );
endinterface

/* rtl/spi_status_dev.sv */
// serial memory front end: command decode and status register
`timescale 1ns/1ps
module spi_status_dev #(
   parameter int PROG_CYCLES = spi_status_pkg::PROG_CYCLES
) (
   // system
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   // link
   spi_link_if.device       link,
   // user side
   output logic [7:0]       status_o,
   output logic             hw_protect_o,
   output logic             prog_start_o
);
   localparam int CW = spi_status_pkg::CNT_W;
   localparam int AW = spi_status_pkg::ADDR_W;
   localparam int STAT_LOCK_IDX  = spi_status_pkg::STAT_LOCK;
   localparam int STAT_BP_HI_IDX = spi_status_pkg::STAT_BP_HI;
   localparam int STAT_BP_LO_IDX = spi_status_pkg::STAT_BP_LO;

   // ***************************************
   // link domain
   // ***************************************
   logic                 first_q;
   logic                 hold_q;
   logic                 paused;
   logic [CW-1:0]        cnt;
   logic [CW-1:0]        next_cnt;
   logic [15:0]          sh;
   logic [15:0]          next_sh;
   logic [AW-1:0]        addr;
   spi_status_pkg::kind_e kind;
   spi_status_pkg::kind_e next_kind;
   logic [7:0]           stat_s1;
   logic [7:0]           stat_s2;
   logic                 so;
   logic                 so_oe;

   // pause starts at once with clock low, else at next fall
   assign paused = link.sck ? hold_q : ~link.hold_n;

   always_ff @(negedge link.sck or posedge link.cs_n or negedge reset_n_i)
   begin
      if (!reset_n_i)
         hold_q <= 1'b0;
      else if (link.cs_n)
         hold_q <= 1'b0;
      else
         hold_q <= ~link.hold_n;
   end

   // first edge of a frame restarts the count
   always_ff @(posedge link.sck or posedge link.cs_n or negedge reset_n_i)
   begin
      if (!reset_n_i)
         first_q <= 1'b1;
      else if (link.cs_n)
         first_q <= 1'b1;
      else if (!paused)
         first_q <= 1'b0;
   end

   always_comb
   begin
      next_sh = first_q ? {15'h0000, link.mosi} : {sh[14:0], link.mosi};
      if (first_q)
         next_cnt = {{(CW-1){1'b0}}, 1'b1};
      else if (cnt == spi_status_pkg::CNT_MAX)
         next_cnt = cnt;
      else
         next_cnt = cnt + 1'b1;
      next_kind = kind;
      if (first_q)
         next_kind = spi_status_pkg::K_NONE;
      if (next_cnt == spi_status_pkg::CNT_OPCODE)
      begin
         case (next_sh[7:0])
            spi_status_pkg::OP_SET_LATCH:   next_kind = spi_status_pkg::K_SET;
            spi_status_pkg::OP_CLEAR_LATCH: next_kind = spi_status_pkg::K_CLEAR;
            spi_status_pkg::OP_STATUS_RD:   next_kind = spi_status_pkg::K_STAT_RD;
            spi_status_pkg::OP_STATUS_WR:   next_kind = spi_status_pkg::K_STAT_WR;
            spi_status_pkg::OP_MEM_RD:      next_kind = spi_status_pkg::K_MEM_RD;
            spi_status_pkg::OP_MEM_WR:      next_kind = spi_status_pkg::K_MEM_WR;
            default:                        next_kind = spi_status_pkg::K_BAD;
         endcase
      end
   end

   // input bits taken on rising edge, frozen while paused
   always_ff @(posedge link.sck or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         cnt  <= '0;
         sh   <= 16'h0000;
         kind <= spi_status_pkg::K_NONE;
      end
      else if (!link.cs_n && !paused)
      begin
         cnt  <= next_cnt;
         sh   <= next_sh;
         kind <= next_kind;
      end
   end

   // low address bits only
   always_ff @(posedge link.sck or negedge reset_n_i)
   begin
      if (!reset_n_i)
         addr <= '0;
      else if (!link.cs_n && !paused && next_cnt == spi_status_pkg::CNT_ADDR)
         addr <= next_sh[AW-1:0];
   end

   // status copy for shifting out
   always_ff @(posedge link.sck or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         stat_s1 <= 8'h00;
         stat_s2 <= 8'h00;
      end
      else
      begin
         stat_s1 <= status_o;
         stat_s2 <= stat_s1;
      end
   end

   // output bits change on falling edge; status repeats per byte
   always_ff @(negedge link.sck or posedge link.cs_n or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         so    <= 1'b0;
         so_oe <= 1'b0;
      end
      else if (link.cs_n)
      begin
         so    <= 1'b0;
         so_oe <= 1'b0;
      end
      else if (link.hold_n)
      begin
         so_oe <= (kind == spi_status_pkg::K_STAT_RD) ||
                  (kind == spi_status_pkg::K_MEM_RD && cnt >= spi_status_pkg::CNT_ADDR);
         if (kind == spi_status_pkg::K_STAT_RD)
            so <= stat_s2[~cnt[2:0]];
         else
            so <= 1'b1;
      end
   end

   assign link.miso    = so;
   assign link.miso_oe = so_oe & ~paused & ~link.cs_n;

   // ***************************************
   // system domain
   // ***************************************
   logic        cs_s1;
   logic        cs_s2;
   logic        cs_s3;
   logic        wp_s1;
   logic        wp_s2;
   logic        frame_end;
   logic        lock;
   logic [1:0]  bp;
   logic        latch;
   logic        busy;
   logic        prog_status;
   logic [2:0]  pend;
   logic [31:0] prog_cnt;
   logic        prog_done;
   logic        hw_prot;
   logic        addr_guarded;
   logic        go_set;
   logic        go_clear;
   logic        go_stat;
   logic        go_mem;

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         cs_s1 <= 1'b1;
         cs_s2 <= 1'b1;
         cs_s3 <= 1'b1;
         wp_s1 <= 1'b1;
         wp_s2 <= 1'b1;
      end
      else
      begin
         cs_s1 <= link.cs_n;
         cs_s2 <= cs_s1;
         cs_s3 <= cs_s2;
         wp_s1 <= link.wp_n;
         wp_s2 <= wp_s1;
      end
   end

   // frame results are still while select is high
   assign frame_end = cs_s2 & ~cs_s3;
   assign hw_prot   = lock & ~wp_s2;

   always_comb
   begin
      case (bp)
         spi_status_pkg::BP_NONE:    addr_guarded = 1'b0;
         spi_status_pkg::BP_QUARTER: addr_guarded = &addr[AW-1:AW-2];
         spi_status_pkg::BP_HALF:    addr_guarded = addr[AW-1];
         default:                    addr_guarded = 1'b1;
      endcase
   end

   assign go_set   = frame_end && kind == spi_status_pkg::K_SET &&
                     cnt == spi_status_pkg::CNT_OPCODE;
   assign go_clear = frame_end && kind == spi_status_pkg::K_CLEAR &&
                     cnt == spi_status_pkg::CNT_OPCODE;
   assign go_stat  = frame_end && kind == spi_status_pkg::K_STAT_WR &&
                     cnt == spi_status_pkg::CNT_STATUS &&
                     latch && !busy && !hw_prot;
   assign go_mem   = frame_end && kind == spi_status_pkg::K_MEM_WR &&
                     cnt >= spi_status_pkg::CNT_BYTE1 && cnt[2:0] == 3'h0 &&
                     cnt != spi_status_pkg::CNT_MAX &&
                     latch && !busy && !addr_guarded;
   assign prog_done = busy && prog_cnt == 32'(PROG_CYCLES - 1);

   // internal write timer
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         busy        <= 1'b0;
         prog_cnt    <= 32'h00000000;
         prog_status <= 1'b0;
         pend        <= 3'h0;
      end
      else if (go_stat || go_mem)
      begin
         busy        <= 1'b1;
         prog_cnt    <= 32'h00000000;
         prog_status <= go_stat;
         pend        <= {sh[STAT_LOCK_IDX], sh[STAT_BP_HI_IDX], sh[STAT_BP_LO_IDX]};
      end
      else if (prog_done)
         busy <= 1'b0;
      else if (busy)
         prog_cnt <= prog_cnt + 32'h00000001;
   end

   // nonvolatile bits switch only at completion
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         lock <= spi_status_pkg::LOCK_RESET;
         bp   <= spi_status_pkg::BP_RESET;
      end
      else if (prog_done && prog_status)
      begin
         lock <= pend[2];
         bp   <= pend[1:0];
      end
   end

   // write latch; a set in the same cycle wins
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         latch <= 1'b0;
      else if (go_set)
         latch <= 1'b1;
      else if (go_clear || prog_done)
         latch <= 1'b0;
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         status_o     <= 8'h00;
         hw_protect_o <= 1'b0;
         prog_start_o <= 1'b0;
      end
      else
      begin
         status_o     <= {lock, 3'h0, bp, latch, busy};
         hw_protect_o <= hw_prot;
         prog_start_o <= go_stat | go_mem;
      end
   end
endmodule

/* rtl/spi_status_host.sv */
// host controller: frames commands and makes the serial clock
`timescale 1ns/1ps
module spi_status_host #(
   parameter int HALF_CYCLES = spi_status_pkg::HOST_HALF_CYCLES,
   parameter int GAP_CYCLES  = spi_status_pkg::HOST_GAP_CYCLES
) (
   // system
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   // link
   spi_link_if.host         link,
   // command
   input  wire logic        start_i,
   input  wire logic [5:0]  bits_i,
   input  wire logic [31:0] tx_i,
   input  wire logic        hold_req_i,
   input  wire logic        wp_low_i,
   // answer
   output logic             ready_o,
   output logic             done_o,
   output logic [7:0]       rx_o
);
   typedef enum logic [1:0] {H_IDLE, H_RUN, H_END, H_GAP} hstate_e;
   hstate_e     st;
   logic [7:0]  div;
   logic [5:0]  nbit;
   logic [5:0]  bits;
   logic [31:0] tx;
   logic [7:0]  rx;
   logic        sck;
   logic        miso_s1;
   logic        miso_s2;
   logic        tick;
   logic        stall;

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         miso_s1 <= 1'b1;
         miso_s2 <= 1'b1;
      end
      else
      begin
         miso_s1 <= link.miso_line;
         miso_s2 <= miso_s1;
      end
   end

   // pause only with clock low
   assign stall = ~link.hold_n & ~sck;
   assign tick  = div == 8'(HALF_CYCLES - 1);

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         link.hold_n <= 1'b1;
         link.wp_n   <= 1'b1;
      end
      else
      begin
         link.hold_n <= ~hold_req_i;
         link.wp_n   <= ~wp_low_i;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         st        <= H_IDLE;
         div       <= 8'h00;
         nbit      <= 6'h00;
         bits      <= 6'h00;
         tx        <= 32'h00000000;
         rx        <= 8'h00;
         sck       <= 1'b0;
         link.cs_n <= 1'b1;
         link.mosi <= 1'b0;
         ready_o   <= 1'b0;
         done_o    <= 1'b0;
         rx_o      <= 8'h00;
      end
      else
      begin
         done_o <= 1'b0;
         case (st)
            H_IDLE:
            begin
               ready_o <= 1'b1;
               if (start_i && ready_o && bits_i != 6'h00)
               begin
                  ready_o   <= 1'b0;
                  link.cs_n <= 1'b0;
                  link.mosi <= tx_i[31];
                  tx        <= {tx_i[30:0], 1'b0};
                  bits      <= bits_i;
                  nbit      <= 6'h00;
                  div       <= 8'h00;
                  st        <= H_RUN;
               end
            end
            H_RUN:
            begin
               if (!stall)
               begin
                  div <= tick ? 8'h00 : div + 8'h01;
                  if (tick && !sck)
                     sck <= 1'b1;
                  else if (tick)
                  begin
                     sck  <= 1'b0;
                     rx   <= {rx[6:0], miso_s2};
                     nbit <= nbit + 6'h01;
                     if (nbit + 6'h01 == bits)
                        st <= H_END;
                     else
                     begin
                        link.mosi <= tx[31];
                        tx        <= {tx[30:0], 1'b0};
                     end
                  end
               end
            end
            H_END:
            begin
               div <= tick ? 8'h00 : div + 8'h01;
               if (tick)
               begin
                  link.cs_n <= 1'b1;
                  rx_o      <= rx;
                  done_o    <= 1'b1;
                  st        <= H_GAP;
               end
            end
            H_GAP:
            begin
               div <= div + 8'h01;
               if (div == 8'(GAP_CYCLES - 1))
                  st <= H_IDLE;
            end
            default: st <= H_IDLE;
         endcase
      end
   end

   assign link.sck = sck;
endmodule

/* rtl/spi_status_pkg.sv */
// constants shared by both ends of the serial status link
package spi_status_pkg;
   // opcodes
   localparam logic [7:0] OP_SET_LATCH   = 8'h06;
   localparam logic [7:0] OP_CLEAR_LATCH = 8'h04;
   localparam logic [7:0] OP_STATUS_RD   = 8'h05;
   localparam logic [7:0] OP_STATUS_WR   = 8'h01;
   localparam logic [7:0] OP_MEM_RD      = 8'h03;
   localparam logic [7:0] OP_MEM_WR      = 8'h02;
   // status bit positions
   localparam int STAT_LOCK   = 7;
   localparam int STAT_BP_HI  = 3;
   localparam int STAT_BP_LO  = 2;
   localparam int STAT_LATCH  = 1;
   localparam int STAT_BUSY   = 0;
   // nonvolatile reset values
   localparam logic       LOCK_RESET = 1'b0;
   localparam logic [1:0] BP_RESET   = 2'h0;
   // clock counts within a frame
   localparam int         CNT_W       = 12;
   localparam logic [11:0] CNT_MAX    = 12'hfff;
   localparam logic [11:0] CNT_OPCODE = 12'h008;
   localparam logic [11:0] CNT_STATUS = 12'h010;
   localparam logic [11:0] CNT_ADDR   = 12'h018;
   localparam logic [11:0] CNT_BYTE1  = 12'h020;
   localparam int         ADDR_W      = 10;
   // protected address top bits
   localparam logic [1:0] BP_NONE     = 2'h0;
   localparam logic [1:0] BP_QUARTER  = 2'h1;
   localparam logic [1:0] BP_HALF     = 2'h2;
   // timing
   localparam int CLK_PERIOD_PS    = 4000;
   localparam int PROG_TIME_US     = 4000;
   // ordered so that no product leaves 32-bit range
   localparam int PROG_CYCLES      = PROG_TIME_US * (1000000 / CLK_PERIOD_PS);
   localparam int HOST_HALF_CYCLES = 2;
   localparam int HOST_GAP_CYCLES  = 8;
   // frame kinds seen by the device
   typedef enum logic [2:0] {
      K_NONE, K_BAD, K_SET, K_CLEAR, K_STAT_RD, K_STAT_WR, K_MEM_RD, K_MEM_WR
   } kind_e;
endpackage

/* verif/spi_eeprom_command_status_tb.sv */
// bench for host and status device joined by the serial link
`timescale 1ns/1ps
module spi_eeprom_command_status_tb;
   logic        clk_i;
   logic        reset_n_i;
   logic        start_i;
   logic [5:0]  bits_i;
   logic [31:0] tx_i;
   logic        hold_req_i;
   logic        wp_low_i;
   logic        ready_o;
   logic        done_o;
   logic [7:0]  rx_o;
   logic [7:0]  status_o;
   logic        hw_protect_o;
   logic        prog_start_o;
   int          fails;
   int          cmp_count;
   int          starts;
   spi_link_if link ();
   spi_status_host spi_status_host_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .link(link),
      .start_i(start_i), .bits_i(bits_i), .tx_i(tx_i), .hold_req_i(hold_req_i),
      .wp_low_i(wp_low_i), .ready_o(ready_o), .done_o(done_o), .rx_o(rx_o));
   spi_status_dev #(.PROG_CYCLES(400)) spi_status_dev_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .link(link), .status_o(status_o), .hw_protect_o(hw_protect_o),
      .prog_start_o(prog_start_o));
   spi_link_properties spi_link_properties_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .cs_n(link.cs_n), .sck(link.sck), .mosi(link.mosi), .miso(link.miso),
      .miso_oe(link.miso_oe), .hold_n(link.hold_n), .wp_n(link.wp_n),
      .miso_line(link.miso_line));
   always #2 clk_i = ~clk_i;
   always @(posedge clk_i)
   begin
      if (prog_start_o === 1'b1) starts++;
   end
   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         $display("ERROR %s expected %h seen %h", name, exp, got);
         fails++;
      end
   endtask
   task automatic cmd(input logic [5:0] n, input logic [31:0] d);
      int k;
      k = 0;
      while (ready_o !== 1'b1 && k < 1000)
      begin
         @(negedge clk_i);
         k++;
      end
      bits_i = n;
      tx_i = d;
      start_i = 1'b1;
      @(negedge clk_i);
      start_i = 1'b0;
      while (done_o !== 1'b1 && k < 2000)
      begin
         @(negedge clk_i);
         k++;
      end
      if (k >= 2000) check("done", 8'h01, 8'h00);
      repeat (12) @(negedge clk_i);
   endtask
   task automatic wait_idle();
      int k;
      k = 0;
      while (status_o[0] !== 1'b0 && k < 3000)
      begin
         @(negedge clk_i);
         k++;
      end
      repeat (4) @(negedge clk_i);
   endtask
   task automatic wsr(input logic [5:0] n, input logic [7:0] d);
      cmd(6'h08, {8'h06, 24'h0});
      cmd(n, {8'h01, d, 16'h0});
      wait_idle();
   endtask
   task automatic t_latch();
      check("reset status", 8'h00, status_o);
      cmd(6'h07, {8'h06, 24'h0});
      check("set 7 clocks", 8'h00, status_o);
      cmd(6'h08, {8'h06, 24'h0});
      check("set 8 clocks", 8'h02, status_o);
      cmd(6'h10, {8'h05, 24'h0});
      check("read latch", 8'h02, rx_o);
      cmd(6'h09, {8'h04, 24'h0});
      check("clear 9 clocks", 8'h02, status_o);
      cmd(6'h08, {8'h04, 24'h0});
      check("clear 8 clocks", 8'h00, status_o);
      $display("test latch done");
   endtask
   task automatic t_sw();
      cmd(6'h08, {8'h06, 24'h0});
      cmd(6'h10, {8'h01, 8'hff, 16'h0});
      cmd(6'h10, {8'h05, 24'h0});
      check("read busy", 8'h03, rx_o);
      check("busy flag", 8'h03, status_o);
      wait_idle();
      check("status written", 8'h8c, status_o);
      check("one start", 8'h01, 8'(starts));
      $display("test status write done");
   endtask
   task automatic t_refuse();
      wp_low_i = 1'b1;
      wsr(6'h10, 8'h00);
      check("hw protect", 8'h01, {7'h0, hw_protect_o});
      check("locked", 8'h8e, status_o);
      wp_low_i = 1'b0;
      cmd(6'h08, {8'h04, 24'h0});
      cmd(6'h10, {8'h01, 8'h00, 16'h0});
      wait_idle();
      check("no latch", 8'h8c, status_o);
      wsr(6'h0f, 8'h00);
      check("15 clocks", 8'h8e, status_o);
      wsr(6'h10, 8'h04);
      check("unlocked", 8'h04, status_o);
      $display("test refuse done");
   endtask
   task automatic t_mem();
      cmd(6'h08, {8'h06, 24'h0});
      cmd(6'h20, {8'h02, 16'h03ff, 8'h55});
      check("protected", 8'h06, status_o);
      cmd(6'h20, {8'h02, 16'hfeff, 8'h55});
      check("mem busy", 8'h07, status_o);
      wait_idle();
      check("mem done", 8'h04, status_o);
      check("mem start", 8'h03, 8'(starts));
      cmd(6'h28, {8'h03, 24'h0});
      check("mem read", 8'hff, rx_o);
      cmd(6'h10, {8'hff, 24'h0});
      check("bad opcode", 8'hff, rx_o);
      $display("test memory done");
   endtask
   task automatic t_hold();
      fork
         cmd(6'h10, {8'h05, 24'h0});
         begin
            // pause lands mid clock-low, away from any clock edge
            repeat (41) @(negedge clk_i);
            hold_req_i = 1'b1;
            repeat (20) @(negedge clk_i);
            hold_req_i = 1'b0;
         end
      join
      check("read held", 8'h04, rx_o);
      $display("test hold done");
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      #200000;
      fails++;
      close_out();
   end
   initial
   begin
      clk_i = 1'b0;
      reset_n_i = 1'b0;
      start_i = 1'b0;
      bits_i = 6'h00;
      tx_i = 32'h0;
      hold_req_i = 1'b0;
      wp_low_i = 1'b0;
      fails = 0;
      cmp_count = 0;
      starts = 0;
      repeat (16) @(negedge clk_i);
      reset_n_i = 1'b1;
      repeat (4) @(negedge clk_i);
      t_latch();
      t_sw();
      t_refuse();
      t_mem();
      t_hold();
      close_out();
   end
endmodule

/* verif/spi_link_properties.sv */
// timing checks on the serial link between host and device
`timescale 1ns/1ps
module spi_link_properties (
   // system
   input wire logic clk_i,
   input wire logic reset_n_i,
   // link
   input wire logic cs_n,
   input wire logic sck,
   input wire logic mosi,
   input wire logic miso,
   input wire logic miso_oe,
   input wire logic hold_n,
   input wire logic wp_n,
   input wire logic miso_line
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   logic       sck_q;
   logic [5:0] rises;
   // sck rises within the frame
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i) sck_q <= 1'b0;
      else sck_q <= sck;
   end
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i) rises <= 6'h00;
      else if (cs_n) rises <= 6'h00;
      else if (sck && !sck_q && rises != 6'h3f) rises <= rises + 6'h01;
   end
   a_float_deselect: assert property (cs_n |-> !miso_oe)
      else $error("output driven while deselected");
   a_line_steady_high: assert property (!cs_n && sck && $past(sck) |-> $stable(miso_line))
      else $error("output moved while clock high");
   a_float_hold: assert property (!hold_n && !sck && !cs_n |-> !miso_oe)
      else $error("output driven during pause");
   a_miso_on_fall: assert property (!cs_n && $past(!cs_n) && $changed(miso) |-> $fell(sck))
      else $error("output changed off falling edge");
   a_mosi_stable_high: assert property (sck && $past(sck) |-> $stable(mosi))
      else $error("input changed while clock high");
   a_cs_idle_low: assert property (cs_n |-> !sck)
      else $error("clock not idle low");
   a_cs_gap_min: assert property ($rose(cs_n) |=> cs_n [*4])
      else $error("deselect too short");
   a_hold_select: assert property (!hold_n |-> !cs_n)
      else $error("pause without select");
   a_hold_still: assert property (!hold_n && !sck |=> $stable(sck))
      else $error("clock moved during pause");
   a_drive_after_op: assert property ($rose(miso_oe) |-> rises >= 6'h08)
      else $error("output before opcode done");
   c_read: cover property ($rose(miso_oe));
   c_hold: cover property ($fell(hold_n));
   c_frame: cover property ($rose(cs_n));
endmodule
